// ---- common/tirq_cfg.svh ----
// constants for the timer interrupt routing block
`ifndef TIRQ_CFG_SVH
`define TIRQ_CFG_SVH
`define TIRQ_CTRL_EN_BIT      7
`define TIRQ_CTRL_SEL_HI      6
`define TIRQ_CTRL_SEL_LO      4
`define TIRQ_CTRL_RSVD_BIT    3
`define TIRQ_CTRL_MASK5_BIT   2
`define TIRQ_CTRL_MASK4_BIT   1
`define TIRQ_CTRL_MASK3_BIT   0
`define TIRQ_EN_RST           1'h0
`define TIRQ_SEL_RST          3'h0
`define TIRQ_MASK_RST         3'h0
`define TIRQ_RDATA_RST        8'h00
`define TIRQ_SLOT_RST         16'h0000
`define TIRQ_NUM_TIMERS       3
`define TIRQ_TIMER_WIDTH      16
`define TIRQ_IRQ_LINES        16
`endif

// ---- common/tirq_pkg.sv ----
// types for the timer interrupt routing block
package tirq_pkg;
  typedef logic [2:0]  tirq_sel_t;
  typedef logic [15:0] tirq_irq_vec_t;

  // map selector code to host IRQ number
  function automatic logic [3:0] tirq_irq_num(input tirq_sel_t sel);
    case (sel)
      3'h0: tirq_irq_num = 4'h3;
      3'h1: tirq_irq_num = 4'h4;
      3'h2: tirq_irq_num = 4'h5;
      3'h3: tirq_irq_num = 4'hA;
      3'h4: tirq_irq_num = 4'h6;
      3'h5: tirq_irq_num = 4'h7;
      3'h6: tirq_irq_num = 4'h9;
      default: tirq_irq_num = 4'hB;
    endcase
  endfunction
endpackage

// ---- hdl/tirq_route.sv ----
// timer interrupt routing: control register and serial IRQ slot request
`timescale 1ns/1ns
`include "tirq_cfg.svh"
module tirq_route
  import tirq_pkg::*;
#(
  parameter int NUM_TIMERS = `TIRQ_NUM_TIMERS
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire logic                  ctrl_wr,
  input  wire logic [7:0]            ctrl_wdata,
  input  wire logic [NUM_TIMERS-1:0] timer_irq,
  output logic      [7:0]            ctrl_rdata,
  output logic                       timer_irq_global_enable,
  output tirq_sel_t                  host_irq_line_select,
  output tirq_irq_vec_t              serirq_slot_req
);

  // size of the host IRQ number space that the slot vector covers
  localparam int IRQ_LINES = `TIRQ_IRQ_LINES;

  // host IRQ number for each selector code, written out on its own so that
  // the slot checks below do not lean on the decode function they guard
  localparam logic [3:0] SEL_IRQ [8] = '{4'h3, 4'h4, 4'h5, 4'hA,
                                         4'h6, 4'h7, 4'h9, 4'hB};

  logic [NUM_TIMERS-1:0] mask_r;        // per-timer mask, bit0 timer #3
  logic [NUM_TIMERS-1:0] gated_irq;     // timer requests that survive the mask
  logic                  any_irq;       // at least one unmasked request
  logic                  fire;          // request that reaches the host
  logic [3:0]            irq_num;       // decoded host IRQ number
  logic [7:0]            rdata_nxt;     // readback image of the fields
  tirq_irq_vec_t         slot_nxt;      // next value of the slot vector

  // control fields; the reserved bit has no storage at all, so a write to it
  // has nothing to land in and cannot leak into the readback
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_irq_global_enable <= `TIRQ_EN_RST;
      host_irq_line_select    <= `TIRQ_SEL_RST;
      mask_r                  <= `TIRQ_MASK_RST;
    end else if (clk_en && ctrl_wr) begin
      timer_irq_global_enable <= ctrl_wdata[`TIRQ_CTRL_EN_BIT];
      host_irq_line_select    <= ctrl_wdata[`TIRQ_CTRL_SEL_HI:`TIRQ_CTRL_SEL_LO];
      mask_r                  <= ctrl_wdata[`TIRQ_CTRL_MASK5_BIT:`TIRQ_CTRL_MASK3_BIT];
    end
  end

  // readback image; the reserved position is left at its zero default
  always_comb begin
    rdata_nxt                                            = `TIRQ_RDATA_RST;
    rdata_nxt[`TIRQ_CTRL_EN_BIT]                         = timer_irq_global_enable;
    rdata_nxt[`TIRQ_CTRL_SEL_HI:`TIRQ_CTRL_SEL_LO]       = host_irq_line_select;
    rdata_nxt[`TIRQ_CTRL_MASK5_BIT:`TIRQ_CTRL_MASK3_BIT] = mask_r;
  end

  // readback register; lags the fields by one enabled cycle, which software
  // never sees because a host read takes far longer than one clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_rdata <= `TIRQ_RDATA_RST;
    end else if (clk_en) begin
      ctrl_rdata <= rdata_nxt;
    end
  end

  // one mask gate per timer of the three 16-bit timer block
  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_gate
    assign gated_irq[i] = timer_irq[i] & mask_r[i];
  end

  // any surviving request, then the global gate in front of the host
  assign any_irq = |gated_irq;
  assign fire    = timer_irq_global_enable & any_irq;
  assign irq_num = tirq_irq_num(host_irq_line_select);

  // one comparator per host line; only the selected line can ever be set
  for (genvar k = 0; k < IRQ_LINES; k++) begin : g_slot
    assign slot_nxt[k] = fire & (irq_num == 4'(k));
  end

  // slot register; registered so the host never sees a decode glitch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serirq_slot_req <= `TIRQ_SLOT_RST;
    end else if (clk_en) begin
      serirq_slot_req <= slot_nxt;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------

  property p_global_gate;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && !timer_irq_global_enable) |=> (serirq_slot_req == 16'h0000);
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("irq with enable off");

  property p_onehot;
    @(posedge clk) disable iff (sys_rst) $onehot0(serirq_slot_req);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one slot");

  property p_rsvd;
    @(posedge clk) disable iff (sys_rst) ctrl_rdata[`TIRQ_CTRL_RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read one");

  property p_mask4;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && timer_irq == 3'b010 && !mask_r[1]) |=> (serirq_slot_req == 16'h0000);
  endproperty
  a_mask4: assert property (p_mask4) else $error("masked timer four fired");

  property p_mask5;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && timer_irq == 3'b100 && !mask_r[2]) |=> (serirq_slot_req == 16'h0000);
  endproperty
  a_mask5: assert property (p_mask5) else $error("masked timer five fired");

  sequence s_req;
    clk_en && timer_irq_global_enable && any_irq && host_irq_line_select == 3'h3;
  endsequence
  property p_irq10;
    @(posedge clk) disable iff (sys_rst) s_req |=> serirq_slot_req == 16'h0400;
  endproperty
  a_irq10: assert property (p_irq10) else $error("irq10 slot not driven");

  // timer #3 has a mask of its own as well
  property p_mask3;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && timer_irq == 3'b001 && !mask_r[0]) |=> (serirq_slot_req == 16'h0000);
  endproperty
  a_mask3: assert property (p_mask3) else $error("masked timer three fired");

  // an open mask on timer #4 does let it through when enabled
  property p_open4;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && timer_irq_global_enable && timer_irq[1] && mask_r[1])
        |=> (serirq_slot_req != 16'h0000);
  endproperty
  a_open4: assert property (p_open4) else $error("open timer four silent");

  // an open mask on timer #5 does let it through when enabled
  property p_open5;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && timer_irq_global_enable && timer_irq[2] && mask_r[2])
        |=> (serirq_slot_req != 16'h0000);
  endproperty
  a_open5: assert property (p_open5) else $error("open timer five silent");

  // a write taken on an enabled edge lands in the enable and select fields one cycle later
  property p_write;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && ctrl_wr) |=>
        (timer_irq_global_enable == $past(ctrl_wdata[`TIRQ_CTRL_EN_BIT])) &&
        (host_irq_line_select == $past(ctrl_wdata[`TIRQ_CTRL_SEL_HI:`TIRQ_CTRL_SEL_LO]));
  endproperty
  a_write: assert property (p_write) else $error("write did not land");

  // with the clock enable low nothing may move
  property p_freeze;
    @(posedge clk) disable iff (sys_rst)
      !clk_en |=> $stable(serirq_slot_req) && $stable(ctrl_rdata) &&
                  $stable(host_irq_line_select) && $stable(timer_irq_global_enable);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // readback shows the enable bit one enabled cycle after it settles
  property p_rd_en;
    @(posedge clk) disable iff (sys_rst)
      clk_en |=> ctrl_rdata[`TIRQ_CTRL_EN_BIT] == $past(timer_irq_global_enable);
  endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable readback wrong");

  // every selector code against its fixed host line
  for (genvar c = 0; c < 8; c++) begin : g_sel_chk
    property p_sel_map;
      @(posedge clk) disable iff (sys_rst)
        (clk_en && timer_irq_global_enable && ((timer_irq & mask_r) != '0) &&
         host_irq_line_select == 3'(c))
          |=> serirq_slot_req == (16'h0001 << SEL_IRQ[c]);
    endproperty
    a_sel_map: assert property (p_sel_map) else $error("wrong host line");
  end

endmodule // tirq_route

// ---- tb/tirq_host.sv ----
// host side model: which IRQ the serial frame would carry
`timescale 1ns/1ns
module tirq_host
  import tirq_pkg::*;
(
  input  wire logic          clk,
  input  wire tirq_irq_vec_t slot_req,
  output int                 irq_num_r
);
  // requested IRQ number, -1 when no slot is asked for, -2 when several are
  always_ff @(posedge clk) begin
    irq_num_r <= -1;
    for (int i = 0; i < 16; i++) begin
      if (slot_req[i]) irq_num_r <= ($countones(slot_req) == 1) ? i : -2;
    end
  end
endmodule // tirq_host

// ---- tb/tb_top.sv ----
// bench: random control writes against an integer model
`timescale 1ns/1ns
module tb_top;
  import tirq_pkg::*;
  logic          clk = 0, sys_rst = 1, clk_en = 1, ctrl_wr = 0;
  logic [7:0]    ctrl_wdata = 8'h00, ctrl_rdata, rd_exp = 8'h00;
  logic [2:0]    timer_irq = 3'h0;
  logic          en_o;
  tirq_sel_t     sel_o;
  tirq_irq_vec_t slot;
  int            errors = 0, tests_run = 0, host_irq;
  int            irq_map[8] = '{3, 4, 5, 10, 6, 7, 9, 11};
  tirq_route i_tirq_route (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .timer_irq(timer_irq), .ctrl_rdata(ctrl_rdata),
    .timer_irq_global_enable(en_o), .host_irq_line_select(sel_o), .serirq_slot_req(slot));
  tirq_host i_tirq_host (.clk(clk), .slot_req(slot), .irq_num_r(host_irq));
  initial forever #4 clk = ~clk;
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_irq(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog: the run needs about 135 cycles
  initial begin
    #20000 errors++;
    results;
  end
  initial begin
    logic [7:0] w;
    logic [2:0] t;
    logic       e;
    void'($urandom(98544));
    repeat (3) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    #1 cmp(ctrl_rdata, 16'h0000);
    cmp({en_o, sel_o}, 16'h0000);
    cmp(slot, 16'h0000);
    cmp_irq(host_irq, -1);
    $display("test reset done");
    // every selector code, random bit3, masks, timers; some writes dropped by clk_en
    for (int n = 0; n < 32; n++) begin
      w = $urandom;
      w[6:4] = n[2:0];
      t = $urandom;
      e = ($urandom % 4) != 0;
      @(posedge clk);
      {ctrl_wr, ctrl_wdata, timer_irq, clk_en} <= {1'b1, w, t, e};
      @(posedge clk);
      {ctrl_wr, clk_en} <= 2'b01;
      if (e) rd_exp = w & 8'hF7;
      repeat (2) @(posedge clk);
      #1 cmp(ctrl_rdata, rd_exp);
      cmp({en_o, sel_o}, rd_exp[7:4]);
      cmp(slot, (rd_exp[7] && (t & rd_exp[2:0])) ?
          16'h1 << irq_map[rd_exp[6:4]] : 0);
      cmp_irq(host_irq, (rd_exp[7] && (t & rd_exp[2:0])) ?
              irq_map[rd_exp[6:4]] : -1);
      $display("test %0d done", n);
    end
    // reset again in mid-run: every field back to zero
    @(posedge clk);
    sys_rst <= 1;
    @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    #1 cmp(ctrl_rdata, 16'h0000);
    cmp(slot, 16'h0000);
    cmp_irq(host_irq, -1);
    $display("test mid-run reset done");
    results;
  end
endmodule // tb_top
